//--- logic/dscb_pkg.sv
// Package for the deserializer strap and configuration register bank.
// Assumes a 32-bit AXI4-Lite register bus and one 100 MHz clock.
`default_nettype none
package dscb_pkg;
   // Byte addresses of the four configuration words and the status word.
   localparam logic [7:0] PEER_ADDR_OFS = 8'h00;
   localparam logic [7:0] OWN_ADDR_OFS = 8'h04;
   localparam logic [7:0] LINK_CFG_OFS = 8'h08;
   localparam logic [7:0] SPREAD_CAL_OFS = 8'h0C;
   localparam logic [7:0] STATUS_OFS = 8'h10;
   // Register indices as printed.
   localparam logic [5:0] PEER_ADDR_IDX = 6'h00;
   localparam logic [5:0] OWN_ADDR_IDX = 6'h01;
   localparam logic [5:0] LINK_CFG_IDX = 6'h02;
   localparam logic [5:0] SPREAD_CAL_IDX = 6'h03;
   localparam logic [5:0] STATUS_IDX = 6'h04;
   // Fixed middle bits of the address fields.
   localparam logic [1:0] PEER_MID = 2'h0;
   localparam logic [1:0] OWN_MID = 2'h1;
   // Link configuration field positions and reset values.
   localparam int SS_POS = 6;
   localparam int AUDIO_POS = 4;
   localparam int PIXEL_RANGE_SETTING_POS = 2;
   localparam int SERIAL_RATE_SETTING_POS = 0;
   localparam logic [1:0] SS_OFF_RST = 2'h0;
   localparam logic [1:0] SS_ON_RST = 2'h1;
   localparam logic AUDIO_RST = 1'b1;
   localparam logic [1:0] PIX_RANGE_RST = 2'h3;
   localparam logic [1:0] SER_RATE_RST = 2'h3;
   // Spread calibration field positions and reset values.
   localparam int FMCAL_POS = 6;
   localparam int SAWTOOTH_DIVIDER_POS = 0;
   localparam logic [1:0] FMCAL_RST = 2'h0;
   localparam logic [4:0] SAWTOOTH_DIVIDER_RST = 5'h00;
   // Three-level strap codes.
   localparam logic [1:0] TRI_LOW = 2'h0;
   localparam logic [1:0] TRI_MID = 2'h1;
   localparam logic [1:0] TRI_HIGH = 2'h2;
   // AXI responses.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      DSCB_WR_IDLE = 2'b00,
      DSCB_WR_RESP = 2'b01
   } dscb_wr_state_t;

   typedef struct packed {
      logic [1:0] addr_low;
      logic [1:0] addr_high;
      logic spread;
      logic rate_low;
   } dscb_straps_t;

   typedef struct packed {
      logic [6:0] peer_address_field;
      logic [6:0] own_address_field;
      logic [1:0] spread_setting;
      logic audio_channel_enable;
      logic [1:0] pixel_range_setting;
      logic [1:0] serial_rate_setting;
      logic [1:0] modulation_calibration_mode;
      logic [4:0] sawtooth_divider;
   } dscb_regs_t;
endpackage
`default_nettype wire

//--- logic/dscb_bank.sv
// Strap latch and configuration register bank of a serial-link deserializer.
// Assumes strap, mode and power-down pins pass through two flops here and an AXI4-Lite master.
// Contract
// - Mode select low gives base control mode, high gives bypass.
// - Spread strap sampled only at power-up or power-down exit.
// - Latched spread strap high enables two percent spread, low none.
// - Rate range strap sampled only at power-up or power-down exit.
// - Rate strap high selects the low output clock range.
// - Rate strap low selects the high output clock range.
// - Three-lane mode outputs clock plus three lanes, 21 bits.
// - Four-lane mode outputs clock plus four lanes, 28 bits.
// - Control traffic uses a UART at 100 kbps to 1 Mbps.
// - Base mode uses I2C or link UART; bypass passes custom UART.
// - Audio supports 4 to 32 bit words, 8 to 192 kHz.
// - Peer address resets to XX00XX0 from straps; bit zero reads zero.
// - Own address resets to XX01XX0 from straps; bit zero reads zero.
// - Spread setting resets to 00 or 01 per latched strap.
// - Pixel range field resets to 11, automatic detection.
// - Serial rate field resets to 11, automatic detection.
// - Modulation calibration resets to 00, calibrate once after lock.
// - Sawtooth divider resets to 00000, automatic calibration.
// - Address straps latched at power-up and each power-down exit.
`timescale 1ns/1ps
`default_nettype none
module dscb_bank #(
   parameter int LANE_BITS_3 = 21,
   parameter int LANE_BITS_4 = 28
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic power_down_n,
   input wire logic link_mode_select,
   input wire logic spread_strap,
   input wire logic rate_range_strap,
   input wire logic four_lane_mode,
   input wire logic [1:0] address_strap_low,
   input wire logic [1:0] address_strap_high,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic bypass_mode,
   output logic spread_enable,
   output logic low_rate_range,
   output logic [5:0] lane_bits,
   output logic [2:0] lane_count,
   output var dscb_pkg::dscb_regs_t config_out
);
   typedef struct packed {
      logic [5:0] s1;
      logic [5:0] s2;
      logic [1:0] pd_sync;
      logic [1:0] mode_sync;
      logic pd_prev;
      logic load;
      dscb_pkg::dscb_straps_t straps;
      dscb_pkg::dscb_regs_t regs;
      logic aw_have;
      logic [7:0] aw_addr;
      logic w_have;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      dscb_pkg::dscb_wr_state_t wst;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } dscb_state_t;

   dscb_state_t st_q;
   dscb_state_t st_d;
   dscb_pkg::dscb_straps_t sp;
   logic [7:0] wbyte;
   logic wok;

   function automatic logic [1:0] dscb_tri(input logic [1:0] c);
      // Maps a three-level strap code onto the two address bits.
      case (c)
         dscb_pkg::TRI_LOW: dscb_tri = 2'h1;
         dscb_pkg::TRI_MID: dscb_tri = 2'h2;
         dscb_pkg::TRI_HIGH: dscb_tri = 2'h3;
         default: dscb_tri = 2'h1;
      endcase
   endfunction

   function automatic logic [31:0] dscb_read(input logic [7:0] a,
                                             input dscb_pkg::dscb_regs_t r,
                                             input logic [3:0] s);
      dscb_read = 32'h0000_0000;
      case (a)
         dscb_pkg::PEER_ADDR_OFS:
            dscb_read = {24'h000000, r.peer_address_field, 1'b0};
         dscb_pkg::OWN_ADDR_OFS:
            dscb_read = {24'h000000, r.own_address_field, 1'b0};
         dscb_pkg::LINK_CFG_OFS:
            dscb_read = {24'h000000, r.spread_setting, 1'b0,
                         r.audio_channel_enable, r.pixel_range_setting,
                         r.serial_rate_setting};
         dscb_pkg::SPREAD_CAL_OFS:
            dscb_read = {24'h000000, r.modulation_calibration_mode, 1'b0,
                         r.sawtooth_divider};
         dscb_pkg::STATUS_OFS:
            dscb_read = {28'h0000000, s};
         default: dscb_read = 32'h0000_0000;
      endcase
   endfunction

   always_comb begin
      st_d = st_q;
      sp = st_q.straps;
      st_d.s1 = {address_strap_low, address_strap_high, spread_strap,
                 rate_range_strap};
      st_d.s2 = st_q.s1;
      st_d.pd_sync = {st_q.pd_sync[0], power_down_n};
      st_d.mode_sync = {st_q.mode_sync[0], link_mode_select};
      st_d.pd_prev = st_q.pd_sync[1];
      // Straps are captured once after reset release and on each
      // power-down exit, then seed the reset values of the fields.
      st_d.load = !st_q.pd_prev && st_q.pd_sync[1];
      if (st_q.load) begin
         sp.addr_low = st_q.s2[5:4];
         sp.addr_high = st_q.s2[3:2];
         sp.spread = st_q.s2[1];
         sp.rate_low = st_q.s2[0];
         st_d.straps = sp;
         // The low pair counts from zero, one step below the high pair.
         st_d.regs.peer_address_field = {dscb_tri(sp.addr_high),
            dscb_pkg::PEER_MID, 2'(dscb_tri(sp.addr_low) - 2'h1),
            1'b0};
         st_d.regs.own_address_field = {dscb_tri(sp.addr_high),
            dscb_pkg::OWN_MID, 2'(dscb_tri(sp.addr_low) - 2'h1),
            1'b0};
         st_d.regs.spread_setting = sp.spread ? dscb_pkg::SS_ON_RST
                                   : dscb_pkg::SS_OFF_RST;
         st_d.regs.audio_channel_enable = dscb_pkg::AUDIO_RST;
         st_d.regs.pixel_range_setting = dscb_pkg::PIX_RANGE_RST;
         st_d.regs.serial_rate_setting = dscb_pkg::SER_RATE_RST;
         st_d.regs.modulation_calibration_mode =
            dscb_pkg::FMCAL_RST;
         st_d.regs.sawtooth_divider = dscb_pkg::SAWTOOTH_DIVIDER_RST;
      end
      // Write channels are taken independently, in either order.
      if (s_axi_awvalid && !st_q.aw_have) begin
         st_d.aw_have = 1'b1;
         st_d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st_q.w_have) begin
         st_d.w_have = 1'b1;
         st_d.w_data = s_axi_wdata;
         st_d.w_strb = s_axi_wstrb;
      end
      wbyte = st_q.w_data[7:0];
      wok = 1'b0;
      case (st_q.wst)
         dscb_pkg::DSCB_WR_IDLE: begin
            if (st_q.aw_have && st_q.w_have) begin
               wok = st_q.aw_addr <= dscb_pkg::SPREAD_CAL_OFS &&
                     st_q.aw_addr[1:0] == 2'h0;
               // Register writes are dropped when a strap reload coincides.
               if (wok && st_q.w_strb[0] && !st_q.load) begin
                  case (st_q.aw_addr)
                     dscb_pkg::PEER_ADDR_OFS:
                        st_d.regs.peer_address_field = wbyte[7:1];
                     dscb_pkg::OWN_ADDR_OFS:
                        st_d.regs.own_address_field = wbyte[7:1];
                     dscb_pkg::LINK_CFG_OFS: begin
                        st_d.regs.spread_setting = wbyte[7:6];
                        st_d.regs.audio_channel_enable = wbyte[4];
                        st_d.regs.pixel_range_setting = wbyte[3:2];
                        st_d.regs.serial_rate_setting = wbyte[1:0];
                     end
                     default: begin
                        st_d.regs.modulation_calibration_mode = wbyte[7:6];
                        st_d.regs.sawtooth_divider = wbyte[4:0];
                     end
                  endcase
               end
               st_d.bresp = wok ? dscb_pkg::RESP_OKAY
                                : dscb_pkg::RESP_SLVERR;
               st_d.aw_have = 1'b0;
               st_d.w_have = 1'b0;
               st_d.wst = dscb_pkg::DSCB_WR_RESP;
            end
         end
         dscb_pkg::DSCB_WR_RESP: begin
            if (s_axi_bready) begin
               st_d.wst = dscb_pkg::DSCB_WR_IDLE;
            end
         end
         default: st_d.wst = dscb_pkg::DSCB_WR_IDLE;
      endcase
      if (st_q.rvalid) begin
         if (s_axi_rready) begin
            st_d.rvalid = 1'b0;
         end
      end else if (s_axi_arvalid) begin
         st_d.rvalid = 1'b1;
         st_d.rdata = dscb_read(s_axi_araddr, st_q.regs,
            {st_q.mode_sync[1], st_q.straps.spread, st_q.straps.rate_low,
             four_lane_mode});
         st_d.rresp = (s_axi_araddr <= dscb_pkg::STATUS_OFS &&
                       s_axi_araddr[1:0] == 2'h0) ? dscb_pkg::RESP_OKAY
                                                  : dscb_pkg::RESP_SLVERR;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= '0;
         st_q.wst <= dscb_pkg::DSCB_WR_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   assign s_axi_awready = !st_q.aw_have;
   assign s_axi_wready = !st_q.w_have;
   assign s_axi_bvalid = st_q.wst == dscb_pkg::DSCB_WR_RESP;
   assign s_axi_bresp = st_q.bresp;
   assign s_axi_arready = !st_q.rvalid;
   assign s_axi_rvalid = st_q.rvalid;
   assign s_axi_rdata = st_q.rdata;
   assign s_axi_rresp = st_q.rresp;
   assign bypass_mode = st_q.mode_sync[1];
   assign spread_enable = st_q.regs.spread_setting != 2'h0;
   assign low_rate_range = st_q.straps.rate_low;
   // Lane width and count selected by the lane mode input.
   assign lane_bits = four_lane_mode ? 6'(LANE_BITS_4)
                                     : 6'(LANE_BITS_3);
   assign lane_count = four_lane_mode ? 3'h4 : 3'h3;
   assign config_out = st_q.regs;
endmodule // dscb_bank
`default_nettype wire

//--- sim/dscb_bank_sva.sv
// Port checker for the strap and configuration register bank.
// Assumes it is bound into dscb_bank with one clock and sync reset.
`timescale 1ns/1ps
`default_nettype none
module dscb_bank_sva (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic power_down_n,
   input wire logic link_mode_select,
   input wire logic spread_strap,
   input wire logic four_lane_mode,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic bypass_mode,
   input wire logic spread_enable,
   input wire logic low_rate_range,
   input wire logic [5:0] lane_bits,
   input wire logic [2:0] lane_count,
   input wire dscb_pkg::dscb_regs_t config_out
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_rd;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence s_wr;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   a_lane_width: assert property (
      {lane_bits, lane_count} == (four_lane_mode ? 9'h0E4 : 9'h0AB))
      else $error("lane width wrong");
   a_mode_follow: assert property (
      $stable(link_mode_select) [*5] |-> bypass_mode == link_mode_select)
      else $error("bypass mode wrong");
   a_spread_on: assert property (
      $rose(power_down_n) |-> ##4 spread_enable == $past(spread_strap, 3))
      else $error("spread enable wrong");
   a_rate_hold: assert property (
      power_down_n [*8] |-> $stable(low_rate_range))
      else $error("rate range moved");
   a_rd_answer: assert property (s_rd |=> s_axi_rvalid)
      else $error("read answer late");
   a_wr_answer: assert property (s_wr |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   a_addr_lsb: assert property (
      s_axi_arvalid && s_axi_arready && s_axi_araddr < 8'h08 |=>
      s_axi_rdata[0] == 1'b0 && s_axi_rdata[31:8] == 24'h0)
      else $error("reserved bits set");
   a_bad_addr: assert property (
      s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h10 |=>
      s_axi_rresp == dscb_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read accepted");
endmodule // dscb_bank_sva
bind dscb_bank dscb_bank_sva i_sva (.aclk, .aresetn, .power_down_n,
   .link_mode_select, .four_lane_mode, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
   .s_axi_arready, .s_axi_araddr, .s_axi_rdata, .s_axi_rresp,
   .s_axi_rvalid, .bypass_mode, .spread_enable, .low_rate_range,
   .lane_bits, .lane_count, .config_out, .spread_strap);
`default_nettype wire

//--- sim/dscb_strap_model.sv
// Strap resistor network in front of the bank's strap pins.
// Assumes the bench changes the wanted straps just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module dscb_strap_model (
   input wire dscb_pkg::dscb_straps_t want,
   output logic [1:0] address_strap_low,
   output logic [1:0] address_strap_high,
   output logic spread_strap,
   output logic rate_range_strap
);
   // Pins follow the resistors at all times; latching is the bank's job.
   always_comb begin
      {address_strap_low, address_strap_high, spread_strap,
         rate_range_strap} = want;
   end
endmodule // dscb_strap_model
`default_nettype wire

//--- sim/testbench.sv
// Self-checking bench for the strap and configuration register bank.
// Assumes package, bank, strap model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic aclk, aresetn, power_down_n, link_mode_select, four_lane_mode;
   logic spread_strap, rate_range_strap, low_rate_range;
   logic [1:0] address_strap_low, address_strap_high;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, seed;
   logic [3:0] s_axi_wstrb;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, bypass_mode, spread_enable;
   logic [5:0] lane_bits;
   logic [2:0] lane_count;
   dscb_pkg::dscb_regs_t config_out;
   dscb_pkg::dscb_straps_t want;
   logic [33:0] rq[$], bq[$];
   int bad_count = 0, checks_done = 0, cyc = 0;
   dscb_bank i_dut (.aclk, .aresetn, .power_down_n, .link_mode_select,
      .spread_strap, .rate_range_strap, .four_lane_mode, .address_strap_low,
      .address_strap_high, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .bypass_mode, .spread_enable, .low_rate_range,
      .lane_bits, .lane_count, .config_out);
   dscb_strap_model i_straps (.want, .address_strap_low,
      .address_strap_high, .spread_strap, .rate_range_strap);
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Expected power-up value of register r from the latched straps.
   function automatic logic [31:0] dflt(input int r);
      if (r < 2)
         return {24'h0, want.addr_high + 2'h1, 1'b0, r[0], want.addr_low, 2'h0};
      return (r == 2) ? (want.spread ? 32'h5F : 32'h1F) : 32'h0;
   endfunction
   task automatic chk(input logic [33:0] e, g);
      checks_done++;
      if (g !== e) begin
         bad_count++;
         $display("Error at %0t: expected %h got %h", $time, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] r = dscb_pkg::RESP_OKAY);
      @(posedge aclk);
      bq.push_back({r, 32'h0});
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_awvalid || s_axi_wvalid);
      while (!s_axi_bvalid) @(posedge aclk);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] r = dscb_pkg::RESP_OKAY);
      @(posedge aclk);
      rq.push_back({r, d});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      while (!s_axi_rvalid) @(posedge aclk);
      s_axi_rready <= 1'b0;
   endtask
   task automatic give_verdict;
      $display("Comparisons %0d, mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc++;
      if (s_axi_rvalid && s_axi_rready)
         chk(rq.pop_front(), {s_axi_rresp, s_axi_rdata});
      if (s_axi_bvalid && s_axi_bready)
         chk(bq.pop_front(), {s_axi_bresp, 32'h0});
      if (cyc == 5000) begin
         bad_count++;
         give_verdict();
      end
   end
   initial begin
      {aresetn, link_mode_select, four_lane_mode, s_axi_awvalid} = '0;
      {s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      power_down_n = 1'b1;
      s_axi_wstrb = 4'hF;
      seed = 32'hDE3B6A12;
      // Every strap code, loaded by reset first and power-down exit after.
      for (int i = 0; i < 3; i++) begin
         want <= {i[1:0], 2'h2 - i[1:0], i[0], !i[0]};
         if (i == 0) begin
            tick(20);
            aresetn <= 1'b1;
         end else begin
            power_down_n <= 1'b0;
            tick(4);
            power_down_n <= 1'b1;
         end
         tick(8);
         for (int r = 0; r < 4; r++)
            rd(8'(r * 4), dflt(r));
         chk(want.spread, spread_enable);
         chk(want.rate_low, low_rate_range);
         rd(dscb_pkg::STATUS_OFS,
            {28'h0, 1'b0, want.spread, want.rate_low, 1'b0});
         chk(10'h0AB, {bypass_mode, lane_bits, lane_count});
      end
      // Straps move while powered: latched values must not follow.
      want <= {2'h1, 2'h1, 1'b1, 1'b0};
      link_mode_select <= 1'b1;
      four_lane_mode <= 1'b1;
      tick(8);
      rd(dscb_pkg::PEER_ADDR_OFS, 32'h48);
      rd(dscb_pkg::LINK_CFG_OFS, 32'h1F);
      rd(dscb_pkg::STATUS_OFS, 32'h0000000B);
      chk(1'b1, low_rate_range);
      chk(10'h2E4, {bypass_mode, lane_bits, lane_count});
      for (int k = 0; k < 4; k++) begin
         seed = lfsr(seed);
         for (int r = 0; r < 4; r++)
            wr(8'(r * 4), seed);
         for (int r = 0; r < 4; r++)
            rd(8'(r * 4), seed & (r < 2 ? 32'hFE : 32'hDF));
         tick(3);
         chk(seed[7:6] != 2'h0, spread_enable);
      end
      wr(8'h14, ~seed, dscb_pkg::RESP_SLVERR);
      rd(8'h14, 32'h0, dscb_pkg::RESP_SLVERR);
      // A write without byte lane zero is answered but changes nothing.
      s_axi_wstrb <= 4'hE;
      wr(dscb_pkg::PEER_ADDR_OFS, ~seed);
      s_axi_wstrb <= 4'hF;
      rd(dscb_pkg::PEER_ADDR_OFS, seed & 32'hFE);
      give_verdict();
   end
endmodule // testbench
`default_nettype wire
